// >>> src/mcg_cfg.svh
`ifndef MCG_CFG_SVH
`define MCG_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define MCG_ADDR_CLKGEN  12'h000
`define MCG_ADDR_SYSCFG1 12'h004
`define MCG_ADDR_STATUS  12'h008

// ----------------------------------------------------------------
// clock_generation_control field positions
// ----------------------------------------------------------------
`define MCG_SRC_LSB   0
`define MCG_IDIV_LSB  2
`define MCG_ODIV_LSB  4
`define MCG_MUL_LSB   8
`define MCG_BAND_LSB  13
`define MCG_CTRL_W    15
`define MCG_CTRL_RST  15'h0000

// ----------------------------------------------------------------
// encodings, limits, reset values
// ----------------------------------------------------------------
`define MCG_SRC_PLL   2'h3
`define MCG_IDIV_MAX  2'h3
`define MCG_ODIV_MAX  4'he
`define MCG_BAND_RSVD 2'h3
`define MCG_BAND_LOW  2'h0
`define MCG_PER_W     12
`define MCG_PER_RST   12'h010
`define MCG_RESP_OK   2'h0
`define MCG_RESP_ERR  2'h2

`endif

// >>> src/mcg_pkg.sv
package mcg_pkg;

  // clock_generation_control register layout
  typedef struct packed {
    logic [1:0] vco_band_select;
    logic [4:0] feedback_multiplier;
    logic [3:0] output_prescale_factor;
    logic [1:0] input_prescale_factor;
    logic [1:0] master_clock_source_select;
  } mcg_ctrl_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic mc;
    logic cpu;
    logic ext_bus;
    logic sys;
  } mcg_en_t;

endpackage : mcg_pkg

// >>> src/mcg_master_clock.sv
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "mcg_cfg.svh"

// Contract
// - source-select field picks generation mechanism
// - bypass divides by idiv+1 times odiv+1
// - zero prescalers: master clock follows oscillator
// - idiv up to 3, odiv up to 14
// - select 11 enables PLL multiplication
// - PLL locks gradually, no abrupt change
// - VCO output divided by odiv+1
// - VCO band field, 11 reserved
// - CPU clock is master or half
// - core and bus controller use CPU clock
// - peripherals get system clock equal CPU
module mcg_master_clock (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // oscillator pin
  input wire logic oscillator_input,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock outputs
  output mcg_pkg::mcg_en_t clk_en,
  output logic master_clock_level,
  output logic [1:0] vco_band
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
  mcg_pkg::mcg_ctrl_t pend_ff, act_ff, nxt_pend;
  logic halve_ff, halve_act_ff, nxt_halve;
  logic [1:0] idiv_cnt_ff;
  logic [3:0] odiv_cnt_ff;
  logic [`MCG_PER_W-1:0] meas_ff, per_cnt_ff, est_ff;
  logic [15:0] acc_ff;
  logic cpu_phase_ff;
  logic osc_rise, pll_mode, ref_tick, vco_tick, nxt_mc, nxt_cpu;
  logic [15:0] acc_sum;
  logic [11:0] aw_addr_ff, ar_addr;
  logic [31:0] w_data_ff, wmask, merged;
  logic [3:0] w_strb_ff;
  logic aw_got_ff, w_got_ff, do_write;
  logic [31:0] rd_val;
  logic rd_ok;

  // ----------------------------------------------------------------
  // oscillator pin synchroniser
  // ----------------------------------------------------------------
  // s1 feeds only s2; edges are seen between s2 and s3
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      osc_s3_ff <= 1'b0;
    end else begin
      osc_s1_ff <= oscillator_input;
      osc_s2_ff <= osc_s1_ff;
      osc_s3_ff <= osc_s2_ff;
    end
  end

  assign osc_rise = osc_s2_ff & ~osc_s3_ff;
  assign pll_mode = (act_ff.master_clock_source_select == `MCG_SRC_PLL);

  // ----------------------------------------------------------------
  // input prescaler and reference period measurement
  // ----------------------------------------------------------------
  // one reference tick per idiv+1 oscillator edges
  always_ff @(posedge clk) begin
    if (rst || nxt_mc && act_ff != pend_ff) begin
      idiv_cnt_ff <= 2'h0;
    end else if (osc_rise) begin
      if (idiv_cnt_ff == act_ff.input_prescale_factor) begin
        idiv_cnt_ff <= 2'h0;
      end else begin
        idiv_cnt_ff <= idiv_cnt_ff + 2'h1;
      end
    end
  end

  assign ref_tick = osc_rise && idiv_cnt_ff == act_ff.input_prescale_factor;

  // clk cycles per reference period, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      per_cnt_ff <= '0;
      meas_ff <= `MCG_PER_RST;
    end else if (ref_tick) begin
      per_cnt_ff <= 12'h001;
      meas_ff <= per_cnt_ff;
    end else if (per_cnt_ff != 12'hfff) begin
      per_cnt_ff <= per_cnt_ff + 12'h001;
    end
  end

  // estimate slews one step per reference tick, so no frequency jump
  always_ff @(posedge clk) begin
    if (rst) begin
      est_ff <= `MCG_PER_RST;
    end else if (ref_tick && est_ff < meas_ff) begin
      est_ff <= est_ff + 12'h001;
    end else if (ref_tick && est_ff > meas_ff && est_ff > 12'h001) begin
      est_ff <= est_ff - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // vco: digital accumulator, mul+1 ticks per reference period
  // ----------------------------------------------------------------
  // at most one tick per clk, so high products saturate at clk rate
  assign acc_sum = acc_ff + {11'h000, act_ff.feedback_multiplier} + 16'h0001;
  assign vco_tick = pll_mode && acc_sum >= {4'h0, est_ff};

  always_ff @(posedge clk) begin
    if (rst || !pll_mode) begin
      acc_ff <= 16'h0000;
    end else if (vco_tick) begin
      acc_ff <= acc_sum - {4'h0, est_ff};
    end else begin
      acc_ff <= acc_sum;
    end
  end

  // ----------------------------------------------------------------
  // output prescaler, shared by both sources
  // ----------------------------------------------------------------
  // pll mode counts vco ticks, bypass counts reference ticks
  always_ff @(posedge clk) begin
    if (rst || nxt_mc && act_ff != pend_ff) begin
      odiv_cnt_ff <= 4'h0;
    end else if (pll_mode ? vco_tick : ref_tick) begin
      if (odiv_cnt_ff == act_ff.output_prescale_factor) begin
        odiv_cnt_ff <= 4'h0;
      end else begin
        odiv_cnt_ff <= odiv_cnt_ff + 4'h1;
      end
    end
  end

  assign nxt_mc = (pll_mode ? vco_tick : ref_tick)
    && odiv_cnt_ff == act_ff.output_prescale_factor;

  // ----------------------------------------------------------------
  // configuration handover at a master clock boundary
  // ----------------------------------------------------------------
  // changing mid-period would cut a pulse short
  always_ff @(posedge clk) begin
    if (rst) begin
      act_ff <= `MCG_CTRL_RST;
      halve_act_ff <= 1'b0;
    end else if (nxt_mc) begin
      act_ff <= pend_ff;
      halve_act_ff <= halve_ff;
    end
  end

  // ----------------------------------------------------------------
  // cpu, bus controller and system enables
  // ----------------------------------------------------------------
  assign nxt_cpu = nxt_mc && (!halve_act_ff || cpu_phase_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_phase_ff <= 1'b0;
    end else if (nxt_mc) begin
      cpu_phase_ff <= halve_act_ff ? ~cpu_phase_ff : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_en <= '0;
    end else begin
      clk_en.mc <= nxt_mc;
      clk_en.cpu <= nxt_cpu;
      clk_en.ext_bus <= nxt_cpu;
      clk_en.sys <= nxt_cpu;
    end
  end

  // direct bypass passes the oscillator waveform itself
  always_ff @(posedge clk) begin
    if (rst) begin
      master_clock_level <= 1'b0;
    end else if (!pll_mode && act_ff.input_prescale_factor == 2'h0
                 && act_ff.output_prescale_factor == 4'h0) begin
      master_clock_level <= osc_s2_ff;
    end else if (nxt_mc) begin
      master_clock_level <= ~master_clock_level;
    end
  end

  // reserved band code falls back to the lowest band
  always_ff @(posedge clk) begin
    if (rst) begin
      vco_band <= `MCG_BAND_LOW;
    end else if (act_ff.vco_band_select == `MCG_BAND_RSVD) begin
      vco_band <= `MCG_BAND_LOW;
    end else begin
      vco_band <= act_ff.vco_band_select;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_got_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // byte lanes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{w_strb_ff[i]}};
    end
  end

  assign merged = ({17'h0, pend_ff} & ~wmask) | (w_data_ff & wmask);

  // output prescale field clamps at its largest legal value, 14
  always_comb begin
    nxt_pend = pend_ff;
    nxt_halve = halve_ff;
    if (do_write && aw_addr_ff == `MCG_ADDR_CLKGEN) begin
      nxt_pend = merged[`MCG_CTRL_W-1:0];
      if (nxt_pend.output_prescale_factor > `MCG_ODIV_MAX) begin
        nxt_pend.output_prescale_factor = `MCG_ODIV_MAX;
      end
    end
    if (do_write && aw_addr_ff == `MCG_ADDR_SYSCFG1 && w_strb_ff[0]) begin
      nxt_halve = w_data_ff[0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff <= `MCG_CTRL_RST;
      halve_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      halve_ff <= nxt_halve;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCG_RESP_OK;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_ff == `MCG_ADDR_CLKGEN
        || aw_addr_ff == `MCG_ADDR_SYSCFG1) ? `MCG_RESP_OK : `MCG_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  assign ar_addr = s_axi_araddr;

  always_comb begin
    rd_val = 32'h0;
    rd_ok = 1'b1;
    case (ar_addr)
      `MCG_ADDR_CLKGEN: rd_val = {17'h0, pend_ff};
      `MCG_ADDR_SYSCFG1: rd_val = {31'h0, halve_ff};
      `MCG_ADDR_STATUS: rd_val = {16'h0, est_ff,
        1'b0, est_ff == meas_ff, pll_mode, halve_act_ff};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `MCG_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `MCG_RESP_OK : `MCG_RESP_ERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
      s_axi_arready <= s_axi_rready;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // osc edges since the last master tick, for the bypass ratio check
  logic [5:0] edge_cnt_ff;

  always_ff @(posedge clk) begin
    if (rst || nxt_mc) begin
      edge_cnt_ff <= 6'h00;
    end else if (osc_rise) begin
      edge_cnt_ff <= edge_cnt_ff + 6'h01;
    end
  end

  sequence s_osc_edge;
    osc_s2_ff && !osc_s3_ff;
  endsequence

  sequence s_direct;
    !pll_mode && act_ff.input_prescale_factor == 2'h0
      && act_ff.output_prescale_factor == 4'h0;
  endsequence

  a_mode_from_field: assert property (
    nxt_mc |=> pll_mode
      == ($past(pend_ff.master_clock_source_select) == 2'h3))
    else $error("mode does not match source select");
  a_direct_follow: assert property (
    s_direct and s_osc_edge |=> clk_en.mc)
    else $error("direct bypass missed an oscillator edge");
  a_bypass_div: assert property (
    !pll_mode && nxt_mc |-> {2'h0, edge_cnt_ff} + 8'h01
      == ({6'h00, act_ff.input_prescale_factor} + 8'h01)
      * ({4'h0, act_ff.output_prescale_factor} + 8'h01))
    else $error("bypass ratio differs from prescalers");
  a_odiv_range: assert property (
    pend_ff.output_prescale_factor <= 4'he)
    else $error("output prescale above fourteen");
  a_smooth_lock: assert property (
    est_ff == $past(est_ff) || est_ff == $past(est_ff) + 12'h001
      || est_ff == $past(est_ff) - 12'h001)
    else $error("pll period estimate jumped");
  a_band_valid: assert property (
    vco_band != 2'h3)
    else $error("reserved vco band driven");
  a_cpu_full: assert property (
    nxt_mc && !halve_act_ff |=> clk_en.cpu)
    else $error("cpu enable missed undivided master tick");
  a_cpu_subset: assert property (
    clk_en.cpu |-> clk_en.mc)
    else $error("cpu enable without master tick");
  a_sys_match: assert property (
    clk_en.sys == clk_en.cpu && clk_en.ext_bus == clk_en.cpu)
    else $error("system or bus enable differs from cpu");
  a_switch_edge: assert property (
    act_ff != $past(act_ff) |-> $past(nxt_mc))
    else $error("source switched off a master boundary");

endmodule : mcg_master_clock

// >>> verif/mcg_osc_model.sv
`timescale 1ns/10ps
// ----
// oscillator source model
// ----
module mcg_osc_model #(
  parameter realtime HALF_NS = 100.0
) (
  // oscillator pin
  output logic osc_out
);
  // free-running square wave; 7 ns skew keeps edges off clk edges
  initial begin
    osc_out = 1'b0;
    #7;
    forever #(HALF_NS) osc_out = ~osc_out;
  end
endmodule : mcg_osc_model

// >>> verif/mcg_master_clock_tb.sv
`timescale 1ns/10ps
`include "mcg_cfg.svh"
module mcg_master_clock_tb;
  // ----
  // signals
  // ----
  logic clk, rst, osc;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, vco_band, rs;
  logic lvl, prv;
  mcg_pkg::mcg_en_t en;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n_mc, n_cpu, n_ext_bus, n_sys, n_hi, n_rise;

  mcg_osc_model osc_src (.osc_out(osc));

  mcg_master_clock dut (
    .clk(clk), .rst(rst), .oscillator_input(osc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .clk_en(en),
    .master_clock_level(lvl), .vco_band(vco_band)
  );

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // cycle ceiling; whole run needs about 14k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // ----
  // tasks
  // ----
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  // both channels offered together, each dropped once taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) aw_ok = 1'b1;
      if (wvalid && wready === 1'b1) w_ok = 1'b1;
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!(aw_ok && w_ok));
    while (bvalid !== 1'b1) @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd_reg(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg

  // counts enables and level edges over n cycles
  task win(input int n);
    n_mc = 0;
    n_cpu = 0;
    n_ext_bus = 0;
    n_sys = 0;
    n_hi = 0;
    n_rise = 0;
    prv = lvl;
    repeat (n) begin
      @(posedge clk);
      n_mc += int'(en.mc === 1'b1);
      n_cpu += int'(en.cpu === 1'b1);
      n_ext_bus += int'(en.ext_bus === 1'b1 && en.cpu === 1'b1);
      n_sys += int'(en.sys === 1'b1 && en.cpu === 1'b1);
      n_hi += int'(lvl === 1'b1);
      n_rise += int'(lvl === 1'b1 && prv === 1'b0);
      prv = lvl;
    end
  endtask : win

  function logic [31:0] cw(input logic [1:0] s, input logic [1:0] i,
      input logic [3:0] o, input logic [4:0] m, input logic [1:0] b);
    mcg_pkg::mcg_ctrl_t c;
    c = '{b, m, o, i, s};
    return {17'h00000, c};
  endfunction : cw

  // osc period is 8 clk, so 960 cycles hold exactly 120 osc edges
  task byp(input logic [1:0] s, input logic [1:0] i,
      input logic [3:0] o, input int div);
    wr(`MCG_ADDR_CLKGEN, cw(s, i, o, 5'h00, 2'h0));
    repeat (16 * div + 16) @(posedge clk);
    win(960);
    check(n_mc, 120 / div);
    check(n_rise, 60 / div);
  endtask : byp

  // pll rate is only approximate, so allow a small band
  task pll(input logic [1:0] i, input logic [3:0] o,
      input logic [4:0] m, input int f);
    wr(`MCG_ADDR_CLKGEN, cw(2'h3, i, o, m, 2'h0));
    repeat (800) @(posedge clk);
    rd_reg(`MCG_ADDR_STATUS);
    check(rd & 32'h6, 32'h6);
    win(800);
    check(n_mc >= 100 * f - 4 && n_mc <= 100 * f + 4, 1);
  endtask : pll

  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (16) @(posedge clk);
    // reset config is direct bypass: level follows the pin
    win(960);
    check(n_mc, 120);
    check(n_hi, 480);
    check(n_rise, 120);
    check(n_cpu, 120);
    // unmapped place
    wr(12'h00c, 32'h0000ffff);
    check(rs, `MCG_RESP_ERR);
    rd_reg(12'h00c);
    check(rd, 32'h00000000);
    check(rs, `MCG_RESP_ERR);
    // bypass dividers, every non-pll select code
    byp(2'h0, 2'h1, 4'h0, 2);
    byp(2'h1, 2'h0, 4'h2, 3);
    byp(2'h2, 2'h3, 4'he, 60);
    byp(2'h0, 2'h3, 4'hf, 60);
    rd_reg(`MCG_ADDR_CLKGEN);
    check(rd, cw(2'h0, 2'h3, 4'he, 5'h00, 2'h0));
    // halved cpu clock feeds core, bus controller, peripherals
    wr(`MCG_ADDR_CLKGEN, cw(2'h0, 2'h0, 4'h0, 5'h00, 2'h0));
    wr(`MCG_ADDR_SYSCFG1, 32'h00000001);
    repeat (600) @(posedge clk);
    win(960);
    check(n_mc, 120);
    check(n_cpu, 60);
    check(n_ext_bus, 60);
    check(n_sys, 60);
    rd_reg(`MCG_ADDR_STATUS);
    check(rd & 32'h1, 32'h1);
    wr(`MCG_ADDR_SYSCFG1, 32'h00000000);
    // pll multiply then divide
    pll(2'h0, 4'h0, 5'h03, 4);
    pll(2'h0, 4'h2, 5'h05, 2);
    pll(2'h1, 4'h0, 5'h07, 4);
    // every band code, the reserved one drives the lowest band
    for (int b = 0; b < 4; b++) begin
      wr(`MCG_ADDR_CLKGEN, cw(2'h0, 2'h0, 4'h0, 5'h00, 2'(b)));
      repeat (64) @(posedge clk);
      check(vco_band, (b == 3) ? 2'h0 : 2'(b));
      rd_reg(`MCG_ADDR_CLKGEN);
      check(rd, cw(2'h0, 2'h0, 4'h0, 5'h00, 2'(b)));
    end
    // single byte lane write leaves the upper byte alone
    wstrb <= 4'h1;
    wr(`MCG_ADDR_CLKGEN, 32'h0000ff02);
    wstrb <= 4'hf;
    rd_reg(`MCG_ADDR_CLKGEN);
    check(rd, cw(2'h2, 2'h0, 4'h0, 5'h00, 2'h3));
    stop_test();
  end
endmodule : mcg_master_clock_tb
